// ===== logic/tcd_top.sv
// two-channel cycle-steal dma engine: registers, request flags, bus sequencer
// assumes the memory side answers with mem_ready on core_clk, byte data in low lane
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "tcd_map.svh"
module tcd_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ext_irq_input_zero,
	input wire logic ext_irq_input_one,
	input wire logic [19:0] periph_irq,
	output logic cpu_hold,
	output logic mem_cyc,
	output logic mem_we,
	output logic mem_wide,
	output logic [19:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ready,
	output logic [1:0] dma_irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	tcd_req_if rq ();
	tcd_pkg::tcd_state_t st_reg;
	logic act_reg;
	logic phase_reg;
	logic xw16_reg;
	logic [19:0] xsrc_reg;
	logic [19:0] xdst_reg;
	logic [15:0] data_reg;
	logic [19:0] mem_addr_reg;
	logic mem_we_reg;
	logic mem_wide_reg;
	logic [15:0] mem_wdata_reg;
	logic [31:0] rdata_reg;
	logic [1:0] irq_reg;
	logic [1:0] en_reg;
	logic [1:0] rep_reg;
	logic [1:0] w16_reg;
	logic [1:0] sinc_reg;
	logic [1:0] dinc_reg;
	logic [1:0] reqf_reg;
	tcd_pkg::tcd_sel_t sel_reg [2];
	logic [19:0] src_reg [2];
	logic [19:0] dst_reg [2];
	logic [19:0] ptr_reg [2];
	logic [15:0] rld_reg [2];
	logic [15:0] cnt_reg [2];
	logic [19:0] eff_src [2];
	logic [19:0] eff_dst [2];
	logic [1:0] elig;
	logic [1:0] grant;
	logic [1:0] done;
	logic [1:0] uf;
	logic [1:0] sw_hit;

	tcd_req_sel u_sel (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.ext_irq_input_zero(ext_irq_input_zero),
		.ext_irq_input_one(ext_irq_input_one),
		.periph_irq(periph_irq),
		.rq(rq.src)
	);

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire rc = reg_addr[5];
	wire [4:0] ro = reg_addr[4:0];
	wire w_ctrl = reg_wr & (ro == `TCD_REG_CTRL);
	wire w_sel = reg_wr & (ro == `TCD_REG_SEL);
	wire w_src = reg_wr & (ro == `TCD_REG_SRC);
	wire w_dst = reg_wr & (ro == `TCD_REG_DST);
	wire w_rld = reg_wr & (ro == `TCD_REG_RLD);
	wire w_sw = reg_wr & (ro == `TCD_REG_SWREQ);
	wire [31:0] rd_ctrl = {26'h0000000, reqf_reg[rc], dinc_reg[rc], sinc_reg[rc],
		w16_reg[rc], rep_reg[rc], en_reg[rc]};
	// an enabled incrementing side reads back the live pointer
	wire src_live = en_reg[rc] & sinc_reg[rc];
	wire dst_live = en_reg[rc] & dinc_reg[rc] & ~sinc_reg[rc];
	wire [19:0] rd_src = src_live ? ptr_reg[rc] : src_reg[rc];
	wire [19:0] rd_dst = dst_live ? ptr_reg[rc] : dst_reg[rc];
	wire [31:0] rd_word = (ro == `TCD_REG_CTRL) ? rd_ctrl :
		(ro == `TCD_REG_SEL) ? {27'h0000000, sel_reg[rc]} :
		(ro == `TCD_REG_SRC) ? {12'h000, rd_src} :
		(ro == `TCD_REG_DST) ? {12'h000, rd_dst} :
		(ro == `TCD_REG_RLD) ? {16'h0000, rld_reg[rc]} :
		(ro == `TCD_REG_CNT) ? {16'h0000, cnt_reg[rc]} : 32'h00000000;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_reg <= 32'h00000000;
		end else if (clk_en) begin
			rdata_reg <= reg_rd ? rd_word : 32'h00000000;
		end
	end
	assign reg_rdata = rdata_reg;

	// ----------------------------------------
	// arbitration and sequencer decode
	// ----------------------------------------
	wire idle = st_reg == tcd_pkg::TCD_ST_IDLE;
	wire start = idle & (|elig);
	wire gch = ~elig[0];
	wire blk = (mem_addr_reg >= `TCD_BLK_LO) & (mem_addr_reg <= `TCD_BLK_HI);
	wire in_rd = st_reg == tcd_pkg::TCD_ST_RD;
	wire in_wr = st_reg == tcd_pkg::TCD_ST_WR;
	wire prog = (in_rd | in_wr) & (blk | mem_ready);
	wire rd_split = xw16_reg & xsrc_reg[0];
	wire wr_split = xw16_reg & xdst_reg[0];
	wire [15:0] rb = blk ? `TCD_DATA_RST : mem_rdata;
	wire [15:0] data_next = ~xw16_reg ? {8'h00, rb[7:0]} :
		~rd_split ? rb :
		phase_reg ? {rb[7:0], data_reg[7:0]} : {8'h00, rb[7:0]};
	wire [19:0] g_src = eff_src[gch];
	wire [19:0] g_dst = eff_dst[gch];
	wire g_w16 = w16_reg[gch];

	assign cpu_hold = ~idle;
	assign mem_cyc = (in_rd | in_wr) & ~blk;
	assign mem_we = mem_we_reg;
	assign mem_wide = mem_wide_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign dma_irq = irq_reg;

	// ----------------------------------------
	// transfer sequencer: read phase(s), then write phase(s)
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= tcd_pkg::TCD_ST_IDLE;
			act_reg <= 1'b0;
			phase_reg <= 1'b0;
			xw16_reg <= 1'b0;
			xsrc_reg <= `TCD_ADDR_RST;
			xdst_reg <= `TCD_ADDR_RST;
			data_reg <= `TCD_DATA_RST;
			mem_addr_reg <= `TCD_ADDR_RST;
			mem_we_reg <= 1'b0;
			mem_wide_reg <= 1'b0;
			mem_wdata_reg <= `TCD_DATA_RST;
		end else if (clk_en) begin
			case (st_reg)
				tcd_pkg::TCD_ST_IDLE: begin
					if (start) begin
						st_reg <= tcd_pkg::TCD_ST_RD;
						act_reg <= gch;
						xw16_reg <= g_w16;
						xsrc_reg <= g_src;
						xdst_reg <= g_dst;
						mem_addr_reg <= g_src;
						mem_we_reg <= 1'b0;
						mem_wide_reg <= g_w16 & ~g_src[0];
					end
				end
				tcd_pkg::TCD_ST_RD: begin
					if (prog) begin
						data_reg <= data_next;
						if (rd_split & ~phase_reg) begin
							phase_reg <= 1'b1;
							mem_addr_reg <= xsrc_reg + `TCD_STEP_BYTE;
						end else begin
							phase_reg <= 1'b0;
							st_reg <= tcd_pkg::TCD_ST_WR;
							mem_addr_reg <= xdst_reg;
							mem_we_reg <= 1'b1;
							mem_wide_reg <= xw16_reg & ~xdst_reg[0];
							mem_wdata_reg <= wr_split ? {8'h00, data_next[7:0]} : data_next;
						end
					end
				end
				tcd_pkg::TCD_ST_WR: begin
					if (prog) begin
						if (wr_split & ~phase_reg) begin
							phase_reg <= 1'b1;
							mem_addr_reg <= xdst_reg + `TCD_STEP_BYTE;
							mem_wdata_reg <= {8'h00, data_reg[15:8]};
						end else begin
							phase_reg <= 1'b0;
							st_reg <= tcd_pkg::TCD_ST_DONE;
							mem_we_reg <= 1'b0;
							mem_wide_reg <= 1'b0;
						end
					end
				end
				default: begin
					st_reg <= tcd_pkg::TCD_ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			wire me = rc == c;
			// both sides incrementing is illegal; source side takes the pointer then
			assign eff_src[c] = sinc_reg[c] ? ptr_reg[c] : src_reg[c];
			assign eff_dst[c] = (dinc_reg[c] & ~sinc_reg[c]) ? ptr_reg[c] : dst_reg[c];
			assign elig[c] = reqf_reg[c] & en_reg[c];
			assign grant[c] = start & (gch == c);
			assign done[c] = (st_reg == tcd_pkg::TCD_ST_DONE) & (act_reg == c);
			assign uf[c] = cnt_reg[c] == `TCD_CNT_RST;
			assign sw_hit[c] = w_sw & me;
			assign rq.sel[c] = sel_reg[c];
			wire fix_ok = ~en_reg[c];
			wire [19:0] step = w16_reg[c] ? `TCD_STEP_WORD : `TCD_STEP_BYTE;
			wire w_sinc = reg_wdata[`TCD_CTRL_SINC];
			wire w_dinc = reg_wdata[`TCD_CTRL_DINC];
			wire [19:0] fresh = (w_dinc & ~w_sinc) ? dst_reg[c] : src_reg[c];
			wire [19:0] again = (dinc_reg[c] & ~sinc_reg[c]) ? dst_reg[c] : src_reg[c];
			always_ff @(posedge core_clk) begin
				if (rst) begin
					en_reg[c] <= 1'b0;
					rep_reg[c] <= 1'b0;
					w16_reg[c] <= 1'b0;
					sinc_reg[c] <= 1'b0;
					dinc_reg[c] <= 1'b0;
					reqf_reg[c] <= 1'b0;
					sel_reg[c] <= `TCD_SEL_RST;
					src_reg[c] <= `TCD_ADDR_RST;
					dst_reg[c] <= `TCD_ADDR_RST;
					ptr_reg[c] <= `TCD_ADDR_RST;
					rld_reg[c] <= `TCD_CNT_RST;
					cnt_reg[c] <= `TCD_CNT_RST;
					irq_reg[c] <= 1'b0;
				end else if (clk_en) begin
					// a new request beats a same-cycle clear
					if (rq.req[c]) begin
						reqf_reg[c] <= 1'b1;
					end else if (grant[c] | (w_ctrl & me & ~reg_wdata[`TCD_CTRL_REQ])) begin
						reqf_reg[c] <= 1'b0;
					end
					// pulse has no input from processor interrupt state
					irq_reg[c] <= done[c] & uf[c];
					if (w_sel & me) begin
						sel_reg[c] <= reg_wdata[4:0];
					end
					if (w_rld & me) begin
						rld_reg[c] <= reg_wdata[15:0];
					end
					if (w_src & me & (sinc_reg[c] | fix_ok)) begin
						src_reg[c] <= reg_wdata[19:0];
					end
					if (w_dst & me & (dinc_reg[c] | fix_ok)) begin
						dst_reg[c] <= reg_wdata[19:0];
					end
					// a restart write overrides a transfer finishing in the same cycle
					if (w_ctrl & me) begin
						en_reg[c] <= reg_wdata[`TCD_CTRL_EN];
						rep_reg[c] <= reg_wdata[`TCD_CTRL_REP];
						w16_reg[c] <= reg_wdata[`TCD_CTRL_W16];
						sinc_reg[c] <= w_sinc;
						dinc_reg[c] <= w_dinc;
						if (reg_wdata[`TCD_CTRL_EN]) begin
							cnt_reg[c] <= rld_reg[c];
							ptr_reg[c] <= fresh;
						end
					end else if (done[c]) begin
						if (uf[c] & rep_reg[c]) begin
							cnt_reg[c] <= rld_reg[c];
							ptr_reg[c] <= again;
						end else begin
							cnt_reg[c] <= cnt_reg[c] - 16'h0001;
							ptr_reg[c] <= ptr_reg[c] + step;
							if (uf[c]) begin
								en_reg[c] <= 1'b0;
							end
						end
					end
				end
			end
		end
	endgenerate
	assign rq.sw_req = sw_hit;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire w0 = reg_wr & ~rc;
	AST_HOLD_OWN: assert property (mem_cyc |-> cpu_hold)
		else $error("bus cycle without processor hold");
	AST_PRIO_ZERO: assert property (clk_en && idle && elig == 2'b11 |=>
		act_reg == 1'b0 && in_rd)
		else $error("channel one served ahead of channel zero");
	AST_BLOCK_SFR: assert property (mem_cyc |->
		!(mem_addr >= `TCD_BLK_LO && mem_addr <= `TCD_BLK_HI))
		else $error("access to own register block");
	AST_SINGLE_OFF: assert property (clk_en && done[0] && uf[0] && !rep_reg[0] && !w0
		|=> !en_reg[0])
		else $error("single mode stayed enabled after underflow");
	AST_REPEAT_RLD: assert property (clk_en && done[0] && uf[0] && rep_reg[0] && !w0
		|=> en_reg[0] && cnt_reg[0] == $past(rld_reg[0]))
		else $error("repeat mode did not reload");
	AST_UF_IRQ: assert property (clk_en && done[1] && uf[1] |=> dma_irq[1] ##1 !dma_irq[1])
		else $error("underflow interrupt pulse wrong");
	AST_EN_RELOAD: assert property (clk_en && w_ctrl && !rc && reg_wdata[`TCD_CTRL_EN]
		|=> cnt_reg[0] == $past(rld_reg[0]) && en_reg[0])
		else $error("enable write did not reload counter");
	AST_REQ_SET: assert property (clk_en && rq.req[1] |=> reqf_reg[1])
		else $error("request flag not set");
	AST_REQ_CLR: assert property (clk_en && grant[0] && !rq.req[0] |=> !reqf_reg[0])
		else $error("request flag not cleared at start");
	AST_FIXED_RO: assert property (clk_en && w_dst && !rc && en_reg[0] && !dinc_reg[0]
		|=> dst_reg[0] == $past(dst_reg[0]))
		else $error("fixed register written while enabled");
	AST_SPLIT_RD: assert property (clk_en && in_rd && rd_split && !phase_reg && prog
		|=> in_rd && mem_addr_reg == $past(mem_addr_reg) + `TCD_STEP_BYTE)
		else $error("odd word read not split");
	AST_CNT_DEC: assert property (clk_en && done[0] && !uf[0] && !w0
		|=> cnt_reg[0] == $past(cnt_reg[0]) - 16'h0001)
		else $error("counter did not decrement");
	CVR_REPEAT: cover property (done[0] && uf[0] && rep_reg[0]);
	CVR_SPLIT: cover property (in_wr && wr_split && phase_reg);
	CVR_BOTH: cover property (idle && elig == 2'b11);
	CVR_BLOCKED: cover property ((in_rd || in_wr) && blk);
endmodule
`default_nettype wire

// ===== pkg/tcd_map.svh
// register offsets, field positions and reset values of the two-channel dma
// assumes a 32-bit register port, channel one mirrored at TCD_CH_STRIDE
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH
// ----------------------------------------
// register offsets inside one channel
// ----------------------------------------
`define TCD_REG_CTRL 5'h00
`define TCD_REG_SEL 5'h04
`define TCD_REG_SRC 5'h08
`define TCD_REG_DST 5'h0c
`define TCD_REG_RLD 5'h10
`define TCD_REG_CNT 5'h14
`define TCD_REG_SWREQ 5'h18
`define TCD_CH_STRIDE 6'h20
// ----------------------------------------
// control register fields
// ----------------------------------------
`define TCD_CTRL_EN 0
`define TCD_CTRL_REP 1
`define TCD_CTRL_W16 2
`define TCD_CTRL_SINC 3
`define TCD_CTRL_DINC 4
`define TCD_CTRL_REQ 5
// ----------------------------------------
// values
// ----------------------------------------
`define TCD_SRC_COUNT 5'h19
`define TCD_BLK_LO 20'h00020
`define TCD_BLK_HI 20'h0003f
`define TCD_STEP_BYTE 20'h00001
`define TCD_STEP_WORD 20'h00002
`define TCD_CNT_RST 16'h0000
`define TCD_ADDR_RST 20'h00000
`define TCD_SEL_RST 5'h00
`define TCD_DATA_RST 16'h0000
`endif

// ===== pkg/tcd_pkg.sv
// types shared by the dma engine files
// assumes tcd_map.svh supplies all numeric constants
`default_nettype none
package tcd_pkg;
	typedef enum logic [1:0] {
		TCD_ST_IDLE = 2'b00,
		TCD_ST_RD = 2'b01,
		TCD_ST_WR = 2'b10,
		TCD_ST_DONE = 2'b11
	} tcd_state_t;
	typedef logic [19:0] tcd_addr_t;
	typedef logic [4:0] tcd_sel_t;
endpackage
`default_nettype wire

// ===== pkg/tcd_req_if.sv
// request carrier between the source selector and the engine core
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface tcd_req_if;
	tcd_pkg::tcd_sel_t sel [2];
	logic [1:0] sw_req;
	logic [1:0] req;
	modport src (input sel, input sw_req, output req);
	modport core (output sel, output sw_req, input req);
endinterface
`default_nettype wire

// ===== logic/tcd_req_sel.sv
// request source selection: external edges, peripheral pulses, software
// assumes periph_irq are one-cycle pulses on core_clk; external pins are async
`timescale 1ns/10ps
`default_nettype none
`include "tcd_map.svh"
module tcd_req_sel (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ext_irq_input_zero,
	input wire logic ext_irq_input_one,
	input wire logic [19:0] periph_irq,
	tcd_req_if.src rq
);
	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] prev_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
		end else if (clk_en) begin
			meta_reg <= {ext_irq_input_one, ext_irq_input_zero};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end
	wire [1:0] fall = prev_reg & ~sync_reg;
	wire [1:0] rise = ~prev_reg & sync_reg;
	wire [1:0] both = fall | rise;
	// ----------------------------------------
	// per channel source mux
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			// code 0 software, 1..4 pin edges, 5..24 peripheral pulses
			wire [24:0] vec = {periph_irq, both, fall, rq.sw_req[c]};
			wire ok = rq.sel[c] < `TCD_SRC_COUNT;
			assign rq.req[c] = ok & vec[rq.sel[c]];
		end
	endgenerate
endmodule
`default_nettype wire

// ===== verification/tcd_mem_model.sv
// memory side of the shared bus: byte array, prompt or with two wait cycles
// assumes one phase per mem_cyc, completed at an edge where mem_ready is high
`timescale 1ns/10ps
`default_nettype none
module tcd_mem_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic mem_cyc,
	input wire logic mem_we,
	input wire logic mem_wide,
	input wire logic [19:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ready
);
	logic [7:0] mem_b [256];
	logic [1:0] wait_cnt;
	logic [15:0] last_rd;
	logic [7:0] a;
	assign a = mem_addr[7:0];
	assign mem_ready = mem_cyc && (!slow || wait_cnt == 2'h2);
	// released data lines show the inverse of the last value, never a stale copy
	assign mem_rdata = (mem_cyc && !mem_we) ? {mem_b[a + 8'h01], mem_b[a]} : ~last_rd;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_b[i] = 8'(i) ^ 8'h5a;
		end
		wait_cnt = 2'h0;
		last_rd = 16'h0000;
	end
	always @(posedge core_clk) begin
		wait_cnt <= (mem_cyc && !mem_ready) ? wait_cnt + 2'h1 : 2'h0;
		if (mem_cyc && !mem_we) begin
			last_rd <= mem_rdata;
		end
		if (mem_cyc && mem_we && mem_ready) begin
			mem_b[a] <= mem_wdata[7:0];
			if (mem_wide) begin
				mem_b[a + 8'h01] <= mem_wdata[15:8];
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/tcd_top_bench.sv
// self-checking bench of the dma engine: register tasks and transfer scenarios
// assumes tcd_mem_model answers the memory side; software never sets both sides incrementing
`timescale 1ns/10ps
`default_nettype none
`include "tcd_map.svh"
module tcd_top_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic clk_en = 1'b1;
	logic ext_irq_input_zero = 1'b1;
	logic ext_irq_input_one = 1'b1;
	logic [19:0] periph_irq = 20'h0;
	logic cpu_hold, mem_cyc, mem_we, mem_wide, mem_ready, slow = 1'b0, hold_q = 1'b0;
	logic [19:0] mem_addr, rd_addr = 20'h0;
	logic [15:0] mem_wdata, mem_rdata;
	logic [1:0] dma_irq;
	int mismatches = 0, check_count = 0, xfers = 0, phases = 0, irqs0 = 0, irqs1 = 0, x;
	always #5 core_clk = ~core_clk;
	tcd_top DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_irq_input_zero(ext_irq_input_zero), .ext_irq_input_one(ext_irq_input_one),
		.periph_irq(periph_irq), .cpu_hold(cpu_hold), .mem_cyc(mem_cyc), .mem_we(mem_we),
		.mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready), .dma_irq(dma_irq));
	tcd_mem_model MEM (.core_clk(core_clk), .slow(slow), .mem_cyc(mem_cyc), .mem_we(mem_we),
		.mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready));
	// ------
	// monitor
	// ------
	always @(posedge core_clk) begin
		hold_q <= cpu_hold;
		if (cpu_hold === 1'b1 && hold_q === 1'b0) xfers++;
		if (mem_cyc === 1'b1 && mem_ready === 1'b1) phases++;
		if (mem_cyc === 1'b1 && mem_ready === 1'b1 && mem_we === 1'b0) rd_addr = mem_addr;
		if (dma_irq[0] === 1'b1) irqs0++;
		if (dma_irq[1] === 1'b1) irqs1++;
	end
	// ------
	// tasks
	// ------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_up();
		mismatches++;
		$display("ERROR at %0t: wait ran out", $time);
		stop_test();
	endtask
	task automatic wr(input logic ch, input logic [4:0] off, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= {ch, off};
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic ch, input logic [4:0] off, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= {ch, off};
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	// waits for one transfer to take the bus and give it back
	task automatic wait_done();
		#1;
		repeat (60) if (cpu_hold !== 1'b1) begin @(posedge core_clk); #1; end
		if (cpu_hold !== 1'b1) give_up();
		repeat (60) if (cpu_hold !== 1'b0) begin @(posedge core_clk); #1; end
		if (cpu_hold !== 1'b0) give_up();
		// one more edge so the monitor has counted an underflow pulse
		@(posedge core_clk);
		#1;
	endtask
	task automatic sw(input logic ch);
		wr(ch, `TCD_REG_SWREQ, 32'h1);
		wait_done();
	endtask
	// callers never pass both incrementing bits in c
	task automatic cfg(input logic ch, input logic [19:0] s, input logic [19:0] d,
		input logic [15:0] r, input logic [4:0] sel, input logic [5:0] c);
		wr(ch, `TCD_REG_SRC, 32'(s));
		wr(ch, `TCD_REG_DST, 32'(d));
		wr(ch, `TCD_REG_RLD, 32'(r));
		wr(ch, `TCD_REG_SEL, 32'(sel));
		wr(ch, `TCD_REG_CTRL, 32'(c));
	endtask
	task automatic pulse(input logic [19:0] bits);
		@(posedge core_clk);
		periph_irq <= bits;
		@(posedge core_clk);
		periph_irq <= 20'h0;
	endtask
	function automatic logic [31:0] pat(input logic [7:0] a);
		return 32'(a ^ 8'h5a);
	endfunction
	// ------
	// scenarios
	// ------
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			for (int o = 0; o < 32; o += 4) begin
				if (o != 24) rd(c[0], 5'(o), 32'h0);
			end
		end
		$display("reset values done");
		cfg(1'b0, 20'h40, 20'h80, 16'h2, 5'h0, 6'h09);
		rd(1'b0, `TCD_REG_CNT, 32'h2);
		sw(1'b0);
		rd(1'b0, `TCD_REG_SRC, 32'h41);
		rd(1'b0, `TCD_REG_CNT, 32'h1);
		sw(1'b0);
		sw(1'b0);
		check(32'(irqs0), 32'h1);
		rd(1'b0, `TCD_REG_CTRL, 32'h08);
		rd(1'b0, `TCD_REG_CNT, 32'hffff);
		check(32'(MEM.mem_b[8'h80]), pat(8'h42));
		$display("single byte mode done");
		wr(1'b1, `TCD_REG_SWREQ, 32'h1);
		rd(1'b1, `TCD_REG_CTRL, 32'h20);
		wr(1'b1, `TCD_REG_CTRL, 32'h0);
		rd(1'b1, `TCD_REG_CTRL, 32'h0);
		wr(1'b1, `TCD_REG_CTRL, 32'h20);
		rd(1'b1, `TCD_REG_CTRL, 32'h0);
		$display("request flag done");
		slow <= 1'b1;
		cfg(1'b1, 20'h51, 20'h90, 16'h1, 5'h0, 6'h17);
		wr(1'b1, `TCD_REG_SRC, 32'h60);
		rd(1'b1, `TCD_REG_SRC, 32'h51);
		x = phases;
		sw(1'b1);
		check(32'(phases - x), 32'h3);
		sw(1'b1);
		check(32'(irqs1), 32'h1);
		rd(1'b1, `TCD_REG_CTRL, 32'h17);
		rd(1'b1, `TCD_REG_CNT, 32'h1);
		check(32'(MEM.mem_b[8'h90]), pat(8'h51));
		check(32'(MEM.mem_b[8'h93]), pat(8'h52));
		wr(1'b1, `TCD_REG_CTRL, 32'h0);
		slow <= 1'b0;
		$display("repeat word mode done");
		cfg(1'b0, 20'h20, 20'ha0, 16'h0, 5'h0, 6'h11);
		x = phases;
		sw(1'b0);
		check(32'(phases - x), 32'h1);
		check(32'(MEM.mem_b[8'ha0]), 32'h0);
		$display("blocked range done");
		// even word read, odd destination: one read phase, two byte writes
		cfg(1'b0, 20'h60, 20'hc1, 16'h0, 5'h0, 6'h05);
		x = phases;
		sw(1'b0);
		check(32'(phases - x), 32'h3);
		check(32'(MEM.mem_b[8'hc1]), pat(8'h60));
		check(32'(MEM.mem_b[8'hc2]), pat(8'h61));
		$display("odd word write done");
		cfg(1'b0, 20'h44, 20'hb0, 16'h5, 5'h5, 6'h01);
		cfg(1'b1, 20'h48, 20'hb4, 16'h5, 5'h5, 6'h01);
		pulse(20'h1);
		wait_done();
		check(32'(rd_addr), 32'h44);
		wait_done();
		check(32'(rd_addr), 32'h48);
		check(32'(MEM.mem_b[8'hb4]), pat(8'h48));
		wr(1'b1, `TCD_REG_CTRL, 32'h0);
		$display("priority done");
		cfg(1'b0, 20'h44, 20'hb8, 16'hffff, 5'h0, 6'h01);
		rd(1'b0, `TCD_REG_CNT, 32'hffff);
		for (int c = 5; c < 26; c++) begin
			wr(1'b0, `TCD_REG_SEL, 32'(c));
			wr(1'b0, `TCD_REG_CTRL, 32'h01);
			x = xfers;
			pulse(c < 25 ? 20'h1 << (c - 5) : 20'hfffff);
			if (c < 25) wait_done();
			repeat (10) @(posedge core_clk);
			check(32'(xfers - x), c < 25 ? 32'h1 : 32'h0);
		end
		for (int c = 1; c < 5; c++) begin
			wr(1'b0, `TCD_REG_SEL, 32'(c));
			wr(1'b0, `TCD_REG_CTRL, 32'h01);
			x = xfers;
			if (c % 2 == 1) ext_irq_input_zero <= 1'b0;
			else ext_irq_input_one <= 1'b0;
			repeat (15) @(posedge core_clk);
			ext_irq_input_zero <= 1'b1;
			ext_irq_input_one <= 1'b1;
			repeat (15) @(posedge core_clk);
			check(32'(xfers - x), c > 2 ? 32'h2 : 32'h1);
		end
		$display("request sources done");
		// a write while frozen must not land
		clk_en <= 1'b0;
		wr(1'b0, `TCD_REG_RLD, 32'h1234);
		clk_en <= 1'b1;
		rd(1'b0, `TCD_REG_RLD, 32'hffff);
		$display("clock enable freeze done");
		wr(1'b0, `TCD_REG_SEL, 32'h0);
		wr(1'b0, `TCD_REG_CTRL, 32'h01);
		slow <= 1'b1;
		x = xfers;
		repeat (3) wr(1'b0, `TCD_REG_SWREQ, 32'h1);
		repeat (40) @(posedge core_clk);
		check(32'(xfers - x), 32'h2);
		$display("request merge done");
		stop_test();
	end
endmodule
`default_nettype wire
